// ==== pkg/rpmc_params.svh ====
/*
 Offsets, field positions and reset values of the reference priority and
 input monitor configuration registers.
 Assumes a byte-wide register port with byte offsets as printed.
*/
`ifndef RPMC_PARAMS_SVH
`define RPMC_PARAMS_SVH
`define RPMC_ADDR_W 8
`define RPMC_DATA_W 8
`define RPMC_OFS_PRIO_13_14 8'h1E
`define RPMC_OFS_IN1_MON 8'h20
`define RPMC_OFS_IN2_MON 8'h21
`define RPMC_OFS_SRC_SELECT 8'h4B
`define RPMC_BIT_PATH_SEL 4
`define RPMC_PRIO_MAIN_RST 8'hFE
`define RPMC_PRIO_SEC_RST 8'h00
`define RPMC_PRIO_MAIN_RST_LO 4'hE
`define RPMC_PRIO_SEC_RST_LO 4'h0
`define RPMC_MON_RST 2'h0
`define RPMC_PRIO_HI 3
`define RPMC_PRIO_LO 0
`define RPMC_BKT_HI 5
`define RPMC_BKT_LO 4
`define RPMC_PRIO_OFF 4'h0
`endif

// ==== pkg/rpmc_pkg.sv ====
/*
 Types shared by the reference priority and monitor configuration bank.
 Assumes rpmc_params.svh supplies the numeric constants.
*/
package rpmc_pkg;
    typedef logic [3:0] rpmc_prio_t;
    typedef logic [1:0] rpmc_bucket_t;
    typedef enum logic [1:0] {
        RPMC_BKT_CFG0 = 2'h0,
        RPMC_BKT_CFG1 = 2'h1,
        RPMC_BKT_CFG2 = 2'h2,
        RPMC_BKT_CFG3 = 2'h3
    } rpmc_bucket_cfg_t;
endpackage

// ==== verilog/rpmc_bank.sv ====
/*
 Register bank: input 13/14 priority with main and secondary path copies,
 path target select, and bucket choice for inputs 1 and 2.
 The input 14 half of the priority register is stored and read back only.
 Monitor registers keep only the bucket field; other bits read as zero.
 Unmapped offsets read zero and ignore writes.
 Assumes a single-cycle register port, read data one cycle after the strobe.
 Assumes no wait states; back-to-back strobes are taken.
 Assumes a select write takes effect for priority accesses from the next cycle.
 Assumes downstream selection and monitor logic sample the registered outputs.
*/
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "rpmc_params.svh"

module rpmc_bank (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [`RPMC_ADDR_W-1:0] addr_i,
    input wire logic [`RPMC_DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [`RPMC_DATA_W-1:0] rdata_o,
    output rpmc_pkg::rpmc_prio_t main_prio13_o,
    output rpmc_pkg::rpmc_prio_t sec_prio13_o,
    output logic main_in13_enable_o,
    output logic sec_in13_enable_o,
    output logic path_target_select_o,
    output rpmc_pkg::rpmc_bucket_t input1_bucket_choice_o,
    output rpmc_pkg::rpmc_bucket_t input2_bucket_choice_o
);
    import rpmc_pkg::*;

    // Stored register images
    logic [`RPMC_DATA_W-1:0] prio_main_reg;
    logic [`RPMC_DATA_W-1:0] prio_sec_reg;
    logic path_sel_reg;
    rpmc_bucket_t bkt1_reg;
    rpmc_bucket_t bkt2_reg;
    logic [`RPMC_DATA_W-1:0] rdata_next;
    // Write strobe per register
    logic wr_sel;
    logic wr_prio;
    logic wr_in1;
    logic wr_in2;

    // Nonzero code means input takes part in selection
    function automatic logic prio_enabled(input rpmc_prio_t p);
        prio_enabled = (p != `RPMC_PRIO_OFF);
    endfunction

    // Monitor register image: only bucket field is stored, rest reads zero
    function automatic logic [`RPMC_DATA_W-1:0] mon_image(input rpmc_bucket_t b);
        mon_image = '0;
        mon_image[`RPMC_BKT_HI:`RPMC_BKT_LO] = b;
    endfunction

    // Input 13 field of a priority register image
    function automatic rpmc_prio_t prio13_field(input logic [`RPMC_DATA_W-1:0] r);
        prio13_field = r[`RPMC_PRIO_HI:`RPMC_PRIO_LO];
    endfunction

    // Exact offset match, used by each write decode
    function automatic logic addr_hit(input logic [`RPMC_ADDR_W-1:0] a,
        input logic [`RPMC_ADDR_W-1:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    // Write strobes decoded per register
    always_comb begin
        wr_sel = wr_i && addr_hit(addr_i, `RPMC_OFS_SRC_SELECT);
        wr_prio = wr_i && addr_hit(addr_i, `RPMC_OFS_PRIO_13_14);
        wr_in1 = wr_i && addr_hit(addr_i, `RPMC_OFS_IN1_MON);
        wr_in2 = wr_i && addr_hit(addr_i, `RPMC_OFS_IN2_MON);
    end

    // Path target select, only bit 4 stored
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            path_sel_reg <= 1'b0;
        end else if (wr_sel) begin
            path_sel_reg <= wdata_i[`RPMC_BIT_PATH_SEL];
        end
    end

    // Main path copy, written while select is 0
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            prio_main_reg <= `RPMC_PRIO_MAIN_RST;
        end else if (wr_prio && !path_sel_reg) begin
            prio_main_reg <= wdata_i;
        end
    end

    // Secondary path copy, written while select is 1
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            prio_sec_reg <= `RPMC_PRIO_SEC_RST;
        end else if (wr_prio && path_sel_reg) begin
            prio_sec_reg <= wdata_i;
        end
    end

    // Input 1 bucket choice
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bkt1_reg <= `RPMC_MON_RST;
        end else if (wr_in1) begin
            bkt1_reg <= wdata_i[`RPMC_BKT_HI:`RPMC_BKT_LO];
        end
    end

    // Input 2 bucket choice, kept apart from input 1
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            bkt2_reg <= `RPMC_MON_RST;
        end else if (wr_in2) begin
            bkt2_reg <= wdata_i[`RPMC_BKT_HI:`RPMC_BKT_LO];
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata_next = '0;
        case (addr_i)
            `RPMC_OFS_PRIO_13_14: begin
                rdata_next = path_sel_reg ? prio_sec_reg : prio_main_reg;
            end
            `RPMC_OFS_IN1_MON: begin
                rdata_next = mon_image(bkt1_reg);
            end
            `RPMC_OFS_IN2_MON: begin
                rdata_next = mon_image(bkt2_reg);
            end
            `RPMC_OFS_SRC_SELECT: begin
                rdata_next[`RPMC_BIT_PATH_SEL] = path_sel_reg;
            end
            default: begin
                rdata_next = '0;
            end
        endcase
    end

    // Read data valid only in the cycle after the read strobe
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            rdata_o <= rdata_next;
        end else begin
            rdata_o <= '0;
        end
    end

    // Main path priority for the selection logic
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            main_prio13_o <= `RPMC_PRIO_MAIN_RST_LO;
        end else begin
            main_prio13_o <= prio13_field(prio_main_reg);
        end
    end

    // Secondary path priority for the selection logic
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sec_prio13_o <= `RPMC_PRIO_SEC_RST_LO;
        end else begin
            sec_prio13_o <= prio13_field(prio_sec_reg);
        end
    end

    // Main path input 13 takes part in selection
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            main_in13_enable_o <= prio_enabled(`RPMC_PRIO_MAIN_RST_LO);
        end else begin
            main_in13_enable_o <= prio_enabled(prio13_field(prio_main_reg));
        end
    end

    // Secondary path input 13 takes part in selection
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sec_in13_enable_o <= prio_enabled(`RPMC_PRIO_SEC_RST_LO);
        end else begin
            sec_in13_enable_o <= prio_enabled(prio13_field(prio_sec_reg));
        end
    end

    // Path target select as seen by the selection logic
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            path_target_select_o <= 1'b0;
        end else begin
            path_target_select_o <= path_sel_reg;
        end
    end

    // Input 1 monitor bucket
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            input1_bucket_choice_o <= `RPMC_MON_RST;
        end else begin
            input1_bucket_choice_o <= bkt1_reg;
        end
    end

    // Input 2 monitor bucket
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            input2_bucket_choice_o <= `RPMC_MON_RST;
        end else begin
            input2_bucket_choice_o <= bkt2_reg;
        end
    end
endmodule

// ==== test/rpmc_host.sv ====
/* Host model of the register port. Assumes one clock, strobes one cycle long. */
`timescale 1ns/100ps
module rpmc_host (
    input wire logic clk_i,
    output logic [7:0] addr_o = 8'h00,
    output logic [7:0] wdata_o = 8'h00,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_o <= a;
        wdata_o <= (a[7:1] == 7'h10) ? d & 8'h30 : d;
        wr_o <= 1'b1;
        @(posedge clk_i);
        wr_o <= 1'b0;
        wdata_o <= ~wdata_o;
    endtask
    // Read data is settled by the falling edge of the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clk_i);
        rd_o <= 1'b0;
        @(negedge clk_i);
    endtask
endmodule

// ==== test/rpmc_bank_asserts.sv ====
/* Bank checker bound to rpmc_bank. Assumes one clock, synchronous reset. */
`timescale 1ns/100ps
module rpmc_bank_chk (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic path_target_select_o,
    input wire logic main_in13_enable_o,
    input wire logic sec_in13_enable_o,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] rdata_o,
    input wire logic [3:0] main_prio13_o,
    input wire logic [3:0] sec_prio13_o,
    input wire logic [1:0] input1_bucket_choice_o,
    input wire logic [1:0] input2_bucket_choice_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence wa(a); wr_i && addr_i == a; endsequence
    sequence prio(s); !(wr_i && addr_i == 8'h4B) ##1
        addr_i == 8'h1E && path_target_select_o == s; endsequence
    chk_main_wr: assert property (prio(0) ##0 wr_i |=> ##1
        main_prio13_o == $past(wdata_i[3:0], 2)) else $error("main write");
    chk_sec_wr: assert property (prio(1) ##0 wr_i |=> ##1
        sec_prio13_o == $past(wdata_i[3:0], 2)) else $error("secondary write");
    chk_rd_back: assert property (prio(0) ##0 rd_i |=> rdata_o[3:0] == main_prio13_o)
        else $error("read back");
    chk_code_off: assert property (main_in13_enable_o == |main_prio13_o) else $error("en");
    chk_sec_off: assert property (sec_in13_enable_o == |sec_prio13_o)
        else $error("sec en");
    chk_reset_vals: assert property (disable iff (1'b0) rst_i [*2] |=>
        main_prio13_o == 4'hE && sec_prio13_o == 4'h0) else $error("reset");
    chk_in1_bkt: assert property (wa(8'h20) |=> ##1
        input1_bucket_choice_o == $past(wdata_i[5:4], 2)) else $error("input 1");
    chk_in2_bkt: assert property (wa(8'h21) |=> ##1
        input2_bucket_choice_o == $past(wdata_i[5:4], 2)) else $error("input 2");
    chk_bkt_apart: assert property (wa(8'h20) |=> ##1 $stable(input2_bucket_choice_o))
        else $error("crosstalk");
endmodule
bind rpmc_bank rpmc_bank_chk chk (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .path_target_select_o(path_target_select_o),
    .main_in13_enable_o(main_in13_enable_o),
    .sec_in13_enable_o(sec_in13_enable_o),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .rdata_o(rdata_o),
    .main_prio13_o(main_prio13_o),
    .sec_prio13_o(sec_prio13_o),
    .input1_bucket_choice_o(input1_bucket_choice_o),
    .input2_bucket_choice_o(input2_bucket_choice_o)
);

// ==== test/test_rpmc_bank.sv ====
/* Bench for rpmc_bank. Assumes rpmc_host drives its register port. */
`timescale 1ns/100ps
module test_rpmc_bank;
    logic clk_sys_i = 0, rst_i = 1, wr_i, rd_i, path_target_select_o, main_in13_enable_o;
    logic sec_in13_enable_o;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic [3:0] main_prio13_o, sec_prio13_o;
    logic [1:0] input1_bucket_choice_o, input2_bucket_choice_o;
    int bad_count = 0, n_compared = 0;
    rpmc_host host (.clk_i(clk_sys_i), .addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i),
        .rd_o(rd_i));
    rpmc_bank dut (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .main_prio13_o(main_prio13_o),
        .sec_prio13_o(sec_prio13_o),
        .main_in13_enable_o(main_in13_enable_o),
        .sec_in13_enable_o(sec_in13_enable_o),
        .path_target_select_o(path_target_select_o),
        .input1_bucket_choice_o(input1_bucket_choice_o),
        .input2_bucket_choice_o(input2_bucket_choice_o)
    );
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        if (bad_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_paths;
        host.rd(8'h1E);
        check({rdata_o, main_prio13_o}, 12'hFEE);
        check(main_in13_enable_o, 1'b1);
        host.wr(8'h4B, 8'h10);
        host.rd(8'h4B);
        check({rdata_o, path_target_select_o, sec_in13_enable_o}, 10'h042);
        host.rd(8'h1E);
        check(rdata_o, 8'h00);
        host.wr(8'h1E, 8'h93);
        host.rd(8'h1E);
        check({rdata_o, sec_in13_enable_o}, 9'h127);
        host.wr(8'h4B, 8'h00);
        host.rd(8'h1E);
        check({rdata_o, sec_prio13_o}, 12'hFE3);
        host.wr(8'h1E, 8'h00);
        host.rd(8'h30);
        check({rdata_o, main_in13_enable_o}, 9'h000);
        check(path_target_select_o, 1'b0);
    endtask
    task automatic t_buckets;
        for (int k = 0; k < 4; k++) begin
            host.wr(8'h20, 8'(k * 16));
            host.wr(8'h21, 8'(48 - k * 16));
            host.rd(8'h20);
            check({rdata_o, input1_bucket_choice_o, input2_bucket_choice_o},
                {8'(k * 16), 2'(k), 2'(3 - k)});
            host.rd(8'h21);
            check(rdata_o, 8'(48 - k * 16));
        end
    endtask
    initial forever #25 clk_sys_i = ~clk_sys_i;
    initial begin
        #100000 bad_count++;
        give_verdict();
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_paths();
        t_buckets();
        give_verdict();
    end
endmodule
